// *** core/fqr_reader.sv ***
// Receiving-side controller for an asynchronous elastic FIFO (single or cascaded).
// Drives master clear, shift-out and output enable; watches the ready flag and data.
// Assumes the FIFO pins are asynchronous to ref_clk; they are synchronised here.
//
// Contract
// - Receiver returns strobe low before next
// - Burst ignores flags, rate up to 35 MHz
// - Writer never overfills in burst
// - Wide devices combine flags through gate
// - Wide empty hold-in needs composite ready
// - Cascade handshakes directly, about 25 MHz
// - Cascade supports 32 words and more
`default_nettype none
module fqr_reader #(
  parameter int WORD_W = fqr_pkg::WORD_W,      // Word width across side-by-side devices
  parameter int LANES = 1,                     // Devices placed side by side
  parameter int CAPACITY = fqr_pkg::DEPTH      // Words in the cascade, for burst bounds
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // User request side
  input wire logic clear_req,                  // Pulse: issue a master clear
  input wire logic burst_mode,                 // Level: read without waiting for flags
  input wire logic [7:0] burst_len,            // Words per burst
  input wire logic take_ready,                 // User can accept a word
  output logic take_valid,                     // Word present on take_data
  output logic [WORD_W-1:0] take_data,         // Word read from the FIFO
  output logic busy,                           // Clearing or bursting
  // FIFO pins
  input wire logic [LANES-1:0] output_ready_flag,  // Per-device ready flags
  input wire logic [WORD_W-1:0] read_data_out,     // FIFO data pins
  output logic shift_out,                          // Shift-out strobe
  output logic master_clear,                       // Active-high master clear
  output logic out_drive_n                         // Active-low output drive enable
);
  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [LANES+WORD_W-1:0] pins_sync;
  logic [LANES-1:0] flags_s;
  logic [WORD_W-1:0] data_s;

  fqr_sync #(.WIDTH(LANES + WORD_W)) u_sync (
    .clk(ref_clk),
    .rst_n(rst_n),
    .d({output_ready_flag, read_data_out}),
    .q(pins_sync)
  );

  assign flags_s = pins_sync[LANES+WORD_W-1:WORD_W];
  assign data_s = pins_sync[WORD_W-1:0];

  // Composite flag: every lane must hold a word
  logic word_ready;
  assign word_ready = &flags_s;

  // Any lane still showing a word; outside burst mode the strobe stays up until every lane has let go,
  // so lanes with different ripple times never see a half-finished shift
  logic any_ready;
  assign any_ready = |flags_s;

  // ************************************************************
  // Sequencer state
  // ************************************************************
  fqr_pkg::fqr_state_e state;                  // Current phase
  fqr_pkg::fqr_state_e next_state;
  logic [7:0] cnt;                             // Pulse width and clear timer
  logic [7:0] next_cnt;
  logic [7:0] left;                            // Words left in a burst
  logic [7:0] next_left;
  logic [WORD_W-1:0] data_q;                   // Captured word
  logic [WORD_W-1:0] next_data_q;
  logic valid_q;                               // Captured word not yet taken
  logic next_valid_q;
  logic so_q;                                  // Registered shift-out pin
  logic next_so_q;
  logic mc_q;                                  // Registered master clear pin
  logic next_mc_q;

  localparam logic [7:0] CLEAR_LEN = 8'(fqr_pkg::CLEAR_CYC);
  localparam logic [7:0] BURST_HALF = 8'(fqr_pkg::BURST_HALF_CYC);
  localparam logic [7:0] FLAG_HALF = 8'(fqr_pkg::FLAG_HALF_CYC);
  localparam logic [7:0] CAP_MAX = 8'(CAPACITY);

  // Next values of the sequencer
  always_comb
  begin
    next_state = state;
    next_cnt = (cnt != 8'h00) ? cnt - 8'h01 : 8'h00;
    next_left = left;
    next_data_q = data_q;
    next_valid_q = valid_q;
    next_so_q = so_q;
    next_mc_q = 1'b0;
    // Word handed to the user
    if (valid_q && take_ready)
    begin
      next_valid_q = 1'b0;
    end
    unique case (state)
      // Hold master clear; the flag is forced low meanwhile
      fqr_pkg::FQR_CLEAR:
      begin
        next_mc_q = 1'b1;
        next_so_q = 1'b0;
        if (cnt == 8'h00)
        begin
          next_mc_q = 1'b0;
          next_state = fqr_pkg::FQR_IDLE;
        end
      end
      // Wait for a composite ready word and room at the user side
      fqr_pkg::FQR_IDLE:
      begin
        next_so_q = 1'b0;
        if (clear_req)
        begin
          next_state = fqr_pkg::FQR_CLEAR;
          next_cnt = CLEAR_LEN;
          next_mc_q = 1'b1;
        end
        else if (burst_mode && !next_valid_q && burst_len != 8'h00)
        begin
          // Bound the burst to what the FIFO can hold
          next_left = (burst_len > CAP_MAX) ? CAP_MAX : burst_len;
          next_state = fqr_pkg::FQR_BURST_HI;
          next_so_q = 1'b1;
          next_cnt = BURST_HALF;
        end
        else if (word_ready && !next_valid_q)
        begin
          // Valid word on the pins: take it, then strobe it out
          next_data_q = data_s;
          next_valid_q = 1'b1;
          next_so_q = 1'b1;
          next_cnt = FLAG_HALF;
          next_state = fqr_pkg::FQR_STROBE_HI;
        end
      end
      // Strobe high until the flag has dropped and the width is met
      fqr_pkg::FQR_STROBE_HI:
      begin
        if (cnt == 8'h00 && !any_ready)
        begin
          next_so_q = 1'b0;
          next_cnt = FLAG_HALF;
          next_state = fqr_pkg::FQR_STROBE_LO;
        end
      end
      // Strobe low: the next word advances into the output stage
      fqr_pkg::FQR_STROBE_LO:
      begin
        if (cnt == 8'h00)
        begin
          next_state = fqr_pkg::FQR_IDLE;
        end
      end
      // Burst high half: capture data as the strobe falls
      fqr_pkg::FQR_BURST_HI:
      begin
        if (cnt == 8'h00)
        begin
          next_so_q = 1'b0;
          next_cnt = BURST_HALF;
          next_state = fqr_pkg::FQR_BURST_LO;
          if (!next_valid_q)
          begin
            next_data_q = data_s;
            next_valid_q = 1'b1;
          end
        end
      end
      // Burst low half: next pulse or finish
      fqr_pkg::FQR_BURST_LO:
      begin
        if (cnt == 8'h00 && !next_valid_q)
        begin
          next_left = left - 8'h01;
          if (left == 8'h01)
          begin
            next_state = fqr_pkg::FQR_IDLE;
          end
          else
          begin
            next_so_q = 1'b1;
            next_cnt = BURST_HALF;
            next_state = fqr_pkg::FQR_BURST_HI;
          end
        end
      end
    endcase
  end

  // Register the sequencer; reset starts with a master clear
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      state <= fqr_pkg::FQR_CLEAR;
      cnt <= CLEAR_LEN;
      left <= 8'h00;
      data_q <= '0;
      valid_q <= 1'b0;
      so_q <= 1'b0;
      mc_q <= 1'b1;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      left <= next_left;
      data_q <= next_data_q;
      valid_q <= next_valid_q;
      so_q <= next_so_q;
      mc_q <= next_mc_q;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign shift_out = so_q;
  assign master_clear = mc_q;
  assign out_drive_n = 1'b0;
  assign take_valid = valid_q;
  assign take_data = data_q;
  assign busy = (state == fqr_pkg::FQR_CLEAR) || (state == fqr_pkg::FQR_BURST_HI)
    || (state == fqr_pkg::FQR_BURST_LO);
endmodule
`default_nettype wire

// *** core/fqr_pkg.sv ***
// Package for the FIFO read-side controller: widths, timing figures, states.
// Assumes a 125 MHz ref_clk driving the controller that faces the FIFO pins.
`default_nettype none
package fqr_pkg;
  // ************************************************************
  // Geometry
  // ************************************************************
  localparam int WORD_W = 4;                 // Bits per stored word
  localparam int DEPTH = 16;                 // Words per single device
  localparam int CASCADE_WORDS = 32;         // Least capacity of a cascade
  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_MHZ = 125;              // Controller clock rate
  localparam int BURST_MHZ = 35;             // Top burst shift rate
  localparam int CASCADE_MHZ = 25;           // Typical cascade handshake rate
  // Timer load per half burst period (each half lasts at least one cycle longer), rounded up so the rate never exceeds the figure
  localparam int BURST_HALF_CYC = (CLK_MHZ + 2 * BURST_MHZ - 1) / (2 * BURST_MHZ);
  // Timer load per half period for handshaked transfers through a cascade; each half lasts at least one cycle longer
  localparam int FLAG_HALF_CYC = (CLK_MHZ + 2 * CASCADE_MHZ - 1) / (2 * CASCADE_MHZ);
  localparam int CLEAR_CYC = 4;              // Master clear timer load; the pulse lasts one cycle longer
  // ************************************************************
  // Read sequencer states
  // ************************************************************
  typedef enum logic [2:0] {
    FQR_CLEAR,
    FQR_IDLE,
    FQR_STROBE_HI,
    FQR_STROBE_LO,
    FQR_BURST_HI,
    FQR_BURST_LO
  } fqr_state_e;
endpackage
`default_nettype wire

// *** core/fqr_sync.sv ***
// Two-flop synchroniser for a bus of pin levels.
// Assumes the inputs are asynchronous to clk; only the second stage is read.
`default_nettype none
module fqr_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Levels
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;        // First stage, read only by the second
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_q;

  // Next values of both stages
  always_comb
  begin
    next_meta = d;
    next_q = meta;
  end

  // Register both stages
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta <= '0;
      q <= '0;
    end
    else
    begin
      meta <= next_meta;
      q <= next_q;
    end
  end
endmodule
`default_nettype wire

// *** bench/fqr_reader_props.sv ***
// Assertions on the read-side controller ports.
// Assumes one clock domain, ref_clk, with synchronous active-low rst_n.
`default_nettype none
module fqr_reader_props #(
  parameter int WORD_W = 4,
  parameter int LANES = 1,
  parameter int CAPACITY = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // User side
  input wire logic clear_req,
  input wire logic burst_mode,
  input wire logic [7:0] burst_len,
  input wire logic take_ready,
  input wire logic take_valid,
  input wire logic [WORD_W-1:0] take_data,
  input wire logic busy,
  // FIFO pins
  input wire logic [LANES-1:0] output_ready_flag,
  input wire logic [WORD_W-1:0] read_data_out,
  input wire logic shift_out,
  input wire logic master_clear,
  input wire logic out_drive_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Checks
  // ****
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_clear_after_rst: assert property ($rose(rst_n) |-> master_clear [*4])
    else $error("master clear too short after reset");
  a_clear_quiet: assert property (master_clear |-> !shift_out)
    else $error("strobe during master clear");
  a_strobe_hold: assert property ($rose(shift_out) && !busy |-> shift_out [*4])
    else $error("strobe high too short");
  a_strobe_rest: assert property ($fell(shift_out) && !busy |-> !shift_out [*4])
    else $error("strobe low too short");
  a_take_pair: assert property ($rose(shift_out) && !busy |-> take_valid && (!$past(take_valid) || $past(take_ready)))
    else $error("word not offered with strobe");
  a_take_hold: assert property (take_valid && !take_ready |=> take_valid && $stable(take_data))
    else $error("offered word lost");
  a_take_drop: assert property (take_valid && take_ready |=> !take_valid || $changed(shift_out))
    else $error("word offered twice");
  a_drive_on: assert property (!out_drive_n)
    else $error("data pins not enabled");
endmodule
bind fqr_reader fqr_reader_props #(.WORD_W(WORD_W), .LANES(LANES), .CAPACITY(CAPACITY)) fqr_reader_props_i (
  .ref_clk(ref_clk), .rst_n(rst_n), .clear_req(clear_req), .burst_mode(burst_mode), .burst_len(burst_len),
  .take_ready(take_ready), .take_valid(take_valid), .take_data(take_data), .busy(busy),
  .output_ready_flag(output_ready_flag), .read_data_out(read_data_out), .shift_out(shift_out),
  .master_clear(master_clear), .out_drive_n(out_drive_n));
`default_nettype wire

// *** bench/fqr_fifo_model.sv ***
// Behavioural model of the 16-word elastic FIFO.
// Assumes the bench drives the write side; no clock.
`default_nettype none
module fqr_fifo_model #(
  parameter int RIPPLE_NS = 16 // Fall-through time to the output stage
) (
  // Read side
  input wire logic master_clear,
  input wire logic shift_out,
  input wire logic out_drive_n,
  output logic output_ready_flag,
  output logic [3:0] read_data_out,
  // Write side
  input wire logic shift_in,
  input wire logic [3:0] write_data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Storage
  // ****
  logic [3:0] q[$]; // Stored words, head at output end
  logic [3:0] stage = 4'h0; // Output stage word
  logic taken = 1'b0; // Strobe still high after a shift
  initial output_ready_flag = 1'b0;
  // Released pins show the inverse word, never a stale copy
  assign read_data_out = out_drive_n ? ~stage : stage;
  // Clear empties positions, output stage keeps its word
  always @(posedge master_clear)
  begin
    q.delete();
    output_ready_flag = 1'b0;
  end
  // Load on shift-in rise, never beyond capacity; a ready output stage counts as stored
  always @(posedge shift_in)
    if (!master_clear && q.size() + int'(output_ready_flag) < fqr_pkg::DEPTH)
      q.push_back(write_data_in);
  // Strobe rise on a ready word shifts it out
  always @(posedge shift_out)
    if (output_ready_flag)
    begin
      output_ready_flag = 1'b0;
      taken = 1'b1;
    end
  always @(negedge shift_out)
    taken = 1'b0;
  // Advance into output stage after strobe falls
  always
  begin
    wait (!output_ready_flag && q.size() > 0 && !taken && !master_clear);
    #(RIPPLE_NS);
    if (q.size() > 0 && !master_clear && !taken)
    begin
      stage = q.pop_front();
      output_ready_flag = 1'b1;
      if (shift_out)
      begin
        #(RIPPLE_NS);
        output_ready_flag = 1'b0;
        taken = 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// *** bench/fqr_reader_tb.sv ***
// Self-checking bench for the read-side controller.
// Assumes the FIFO model and the bound checker are compiled first.
`default_nettype none
module fqr_reader_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Signals
  // ****
  logic ref_clk = 1'b0, rst_n = 1'b0, clear_req = 1'b0, burst_mode = 1'b0, take_ready = 1'b0;
  logic [7:0] burst_len = 8'h00;
  logic take_valid, busy, shift_out, master_clear, out_drive_n, flag, shift_in = 1'b0;
  logic [3:0] take_data, rdata, wdata = 4'h0;
  int error_cnt = 0, compares = 0, cyc = 0;
  always #4 ref_clk = ~ref_clk;
  fqr_reader #(.WORD_W(4), .LANES(1), .CAPACITY(16)) fqr_reader_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .clear_req(clear_req), .burst_mode(burst_mode), .burst_len(burst_len), .take_ready(take_ready),
    .take_valid(take_valid), .take_data(take_data), .busy(busy), .output_ready_flag(flag),
    .read_data_out(rdata), .shift_out(shift_out), .master_clear(master_clear), .out_drive_n(out_drive_n));
  // Ripple time off the clock grid, so the flag never rises and the data never changes on a sampling edge
  fqr_fifo_model #(.RIPPLE_NS(15)) fqr_fifo_model_i (.master_clear(master_clear), .shift_out(shift_out),
    .out_drive_n(out_drive_n), .output_ready_flag(flag), .read_data_out(rdata), .shift_in(shift_in),
    .write_data_in(wdata));
  // Cut a hang short
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      error_cnt++;
      give_verdict();
    end
  end
  // ****
  // Helpers
  // ****
  task give_verdict;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk_word(input logic [3:0] e, input logic [3:0] g);
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED %0t word %h expected %h", $time, g, e);
    end
  endtask
  task chk_bit(input logic e, input logic g);
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED %0t bit %b expected %b", $time, g, e);
    end
  endtask
  task wait_cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task push(input logic [3:0] w);
    wdata = w;
    shift_in = 1'b1;
    wait_cyc(1);
    shift_in = 1'b0;
    wait_cyc(1);
  endtask
  task pull(input logic [3:0] e);
    int n;
    n = 0;
    while (take_valid !== 1'b1 && n < 200)
    begin
      wait_cyc(1);
      n++;
    end
    chk_word(e, take_data);
    take_ready = 1'b1;
    wait_cyc(1);
    take_ready = 1'b0;
    wait_cyc(1);
  endtask
  // ****
  // Scenarios
  // ****
  task t_reset;
    chk_bit(1'b1, master_clear);
    chk_bit(1'b0, flag);
    chk_bit(1'b0, take_valid);
  endtask
  task t_stream;
    wait_cyc(10);
    for (int i = 0; i < 16; i++)
      push(4'(i * 7 + 3));
    for (int i = 0; i < 16; i++)
      pull(4'(i * 7 + 3));
    wait_cyc(20);
    chk_bit(1'b0, flag);
    chk_word(4'hc, rdata);
  endtask
  task t_burst;
    for (int i = 0; i < 5; i++)
      push(4'(i + 9));
    burst_len = 8'h04;
    burst_mode = 1'b1;
    pull(4'h9);
    pull(4'ha);
    chk_bit(1'b1, busy);
    burst_mode = 1'b0;
    for (int i = 2; i < 5; i++)
      pull(4'(i + 9));
  endtask
  task t_clear;
    push(4'h6);
    push(4'h2);
    wait_cyc(20);
    chk_bit(1'b1, flag);
    clear_req = 1'b1;
    wait_cyc(1);
    clear_req = 1'b0;
    wait_cyc(3);
    chk_bit(1'b0, flag);
    pull(4'h6);
    wait_cyc(20);
    chk_bit(1'b0, take_valid);
    push(4'hb);
    pull(4'hb);
  endtask
  initial
  begin
    wait_cyc(8);
    rst_n = 1'b1;
    wait_cyc(1);
    t_reset();
    t_stream();
    t_burst();
    t_clear();
    give_verdict();
  end
endmodule
`default_nettype wire
